//--- hdl/brm_defs.svh
`ifndef BRM_DEFS_SVH
`define BRM_DEFS_SVH

// Register byte offsets.
`define BRM_ADDR_CTRL          8'h00
`define BRM_ADDR_STATUS        8'h04
`define BRM_ADDR_PULSES        8'h08
`define BRM_ADDR_CYCLES        8'h0c

// Control register fields.
`define BRM_RATE_BIT_WEIGHT_1  0
`define BRM_RATE_BIT_WEIGHT_32 5
`define BRM_CTRL_CLEAR         8
`define BRM_CTRL_ENABLE_N      9
`define BRM_CTRL_STROBE        10
`define BRM_CTRL_UNITY         11
`define BRM_CTRL_UNITY_SRC     12
`define BRM_CTRL_MSB           12
`define BRM_CTRL_RESET         13'h0e00
`define BRM_CTRL_MASK          13'h1f3f

// Status register fields.
`define BRM_STAT_RATE_OUT_N    8
`define BRM_STAT_GATED_OUT     9
`define BRM_STAT_ENABLE_OUT_N  10

// Pulse statistics fields.
`define BRM_PULSE_GATED_LSB    8

// Counter timing.
`define BRM_COUNT_WIDTH        6
`define BRM_COUNT_LAST         6'h3f

`endif

//--- hdl/brm_pkg.sv
package brm_pkg;

    typedef enum logic
    {
        BRM_UNITY_REG   = 1'b0,
        BRM_UNITY_CLOCK = 1'b1
    } brm_unity_src_t;

    typedef enum logic [1:0]
    {
        BRM_IDLE  = 2'b00,
        BRM_READ  = 2'b01,
        BRM_WRITE = 2'b10
    } brm_phase_t;

endpackage : brm_pkg

//--- hdl/brm_step_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "brm_defs.svh"

module brm_step_counter
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       step,
    output var  logic [5:0] count,
    output var  logic       terminal
);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= 6'h00;
        end
        else if (clear)
        begin
            count <= 6'h00;
        end
        else if (step)
        begin
            count <= count + 6'h01;
        end
    end

    assign terminal = (count == `BRM_COUNT_LAST);

endmodule : brm_step_counter

`default_nettype wire

//--- hdl/brm_rate_decode.sv
`timescale 1ns/1ps
`default_nettype none

module brm_rate_decode
(
    input  wire logic [5:0] rate,
    input  wire logic [5:0] count,
    input  wire logic       gate,
    output var  logic       any_hit
);

    logic [5:0] hit;

    // Weight 2^k fires when the low 6-k count bits equal a single one in
    // their top position, so the six patterns never coincide.
    for (genvar k = 0; k < 6; k++)
    begin : g_bit
        localparam int W = 6 - k;
        logic [W-1:0] pattern;
        assign pattern = W'(1) << (W - 1);
        assign hit[k]  = rate[k] & (count[W-1:0] == pattern);
    end

    assign any_hit = gate & (|hit);

endmodule : brm_rate_decode

`default_nettype wire

//--- hdl/brm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "brm_defs.svh"

module brm_top
    import brm_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    output var  logic        rate_out_n,
    output var  logic        gated_out,
    output var  logic        enable_out_n
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    brm_phase_t                phase;
    logic [7:0]                dp_addr;
    logic                      addr_ok;
    logic [`BRM_CTRL_MSB:0]    ctrl;
    logic [`BRM_CTRL_MSB:0]    next_ctrl;
    logic [31:0]               rd_val;

    logic [5:0]                rate;
    logic                      clear;
    logic                      enable_n;
    logic                      strobe;
    logic                      unity_bit;
    brm_unity_src_t            unity_src;

    logic [5:0]                count;
    logic                      terminal;
    logic                      active;
    logic                      wrap;
    logic                      any_hit;
    logic                      clock_phase;
    logic                      next_unity;
    logic                      next_rate_out_n;
    logic                      next_gated_out;
    logic                      next_enable_out_n;

    logic [6:0]                z_run;
    logic [6:0]                y_run;
    logic [6:0]                z_last;
    logic [6:0]                y_last;
    logic [31:0]               cycles;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: address phase capture.

    assign addr_ok = hsel & htrans[1] & hready;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase <= BRM_IDLE;
        end
        else if (addr_ok)
        begin
            phase <= hwrite ? BRM_WRITE : BRM_READ;
        end
        else
        begin
            phase <= BRM_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_addr <= 8'h00;
        end
        else if (addr_ok)
        begin
            dp_addr <= haddr[7:0];
        end
    end

    // hreadyout is low in reset and until the first clock edge after it; the slave then never inserts wait states and never signals an error.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register.

    always_comb
    begin
        next_ctrl = ctrl;
        unique case (phase)
            BRM_WRITE:
            begin
                if (dp_addr == `BRM_ADDR_CTRL)
                begin
                    next_ctrl = hwdata[`BRM_CTRL_MSB:0] & `BRM_CTRL_MASK;
                end
            end
            BRM_IDLE, BRM_READ:
            begin
                next_ctrl = ctrl;
            end
            default:
            begin
                next_ctrl = ctrl;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl <= `BRM_CTRL_RESET;
        end
        else
        begin
            ctrl <= next_ctrl;
        end
    end

    // Rate is read live every cycle, so software may change it freely.
    assign rate      = ctrl[`BRM_RATE_BIT_WEIGHT_32:`BRM_RATE_BIT_WEIGHT_1];
    assign clear     = ctrl[`BRM_CTRL_CLEAR];
    assign enable_n  = ctrl[`BRM_CTRL_ENABLE_N];
    assign strobe    = ctrl[`BRM_CTRL_STROBE];
    assign unity_bit = ctrl[`BRM_CTRL_UNITY];
    assign unity_src = brm_unity_src_t'(ctrl[`BRM_CTRL_UNITY_SRC]);

    ////////////////////////////////////////////////////////////////////////
    // Read data.

    // Control reads see a write that completes in the same cycle.
    always_comb
    begin
        rd_val = 32'h0000_0000;
        unique case (haddr[7:0])
            `BRM_ADDR_CTRL:
            begin
                rd_val[`BRM_CTRL_MSB:0] = next_ctrl;
            end
            `BRM_ADDR_STATUS:
            begin
                rd_val[5:0]                    = count;
                rd_val[`BRM_STAT_RATE_OUT_N]   = rate_out_n;
                rd_val[`BRM_STAT_GATED_OUT]    = gated_out;
                rd_val[`BRM_STAT_ENABLE_OUT_N] = enable_out_n;
            end
            `BRM_ADDR_PULSES:
            begin
                rd_val[6:0]                         = z_last;
                rd_val[`BRM_PULSE_GATED_LSB +: 7]   = y_last;
            end
            `BRM_ADDR_CYCLES:
            begin
                rd_val = cycles;
            end
            default:
            begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if (addr_ok && !hwrite)
        begin
            hrdata <= rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter and rate decoding.

    assign active = ~clear & ~strobe & ~enable_n;
    assign wrap   = active & terminal;

    brm_step_counter u_counter
    (
        .clk      (hclk),
        .rst_n    (hresetn),
        .clear    (clear),
        .step     (active),
        .count    (count),
        .terminal (terminal)
    );

    brm_rate_decode u_decode
    (
        .rate     (rate),
        .count    (count),
        .gate     (active),
        .any_hit  (any_hit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Emulated input clock for the unity path.

    // Toggles every cycle so a gated output fed from it shows a clock wave.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            clock_phase <= 1'b0;
        end
        else
        begin
            clock_phase <= ~clock_phase;
        end
    end

    always_comb
    begin
        unique case (unity_src)
            BRM_UNITY_CLOCK:
            begin
                next_unity = ~clock_phase;
            end
            BRM_UNITY_REG:
            begin
                next_unity = unity_bit;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Output stage.

    // A rate of zero never hits, so the raw output stays high.
    assign next_rate_out_n   = ~any_hit;
    // Low unity holds the gated output high; inhibited decode passes unity inverted.
    assign next_gated_out    = ~(next_rate_out_n & next_unity);
    // Clear forces enable high and counting stops; low while count is 63 and enable_n is low, even when strobe holds it there.
    assign next_enable_out_n = ~(~clear & ~enable_n & terminal);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rate_out_n   <= 1'b1;
            gated_out    <= 1'b1;
            enable_out_n <= 1'b1;
        end
        else
        begin
            rate_out_n   <= next_rate_out_n;
            gated_out    <= next_gated_out;
            enable_out_n <= next_enable_out_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pulse statistics per 64-count cycle.

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            z_run <= 7'h00;
            y_run <= 7'h00;
        end
        else if (clear || wrap)
        begin
            z_run <= 7'h00;
            y_run <= 7'h00;
        end
        else if (active)
        begin
            z_run <= z_run + {6'h00, ~next_rate_out_n};
            y_run <= y_run + {6'h00, next_gated_out};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            z_last <= 7'h00;
            y_last <= 7'h00;
        end
        else if (wrap)
        begin
            z_last <= z_run + {6'h00, ~next_rate_out_n};
            y_last <= y_run + {6'h00, next_gated_out};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cycles <= 32'h0000_0000;
        end
        else if (wrap)
        begin
            cycles <= cycles + 32'h0000_0001;
        end
    end

    // Stage cascading is wiring outside this block.

endmodule : brm_top

`default_nettype wire

//--- test/brm_checker.sv
`timescale 1ns/1ps
`default_nettype none

module brm_checker
(
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        rate_out_n,
    input wire logic        gated_out,
    input wire logic        enable_out_n
);

default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);

wire logic rd = hsel && htrans[1] && hready && !hwrite;

a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
a_ready_high: assert property ($past(hresetn) |-> hreadyout) else $error("hreadyout low");
a_reset_idle: assert property (disable iff (1'b0) !hresetn |-> rate_out_n && gated_out &&
    enable_out_n && !hreadyout) else $error("outputs not idle in reset");
a_rdata_hold: assert property (!$past(rd) |-> $stable(hrdata)) else $error("hrdata moved");
a_unmapped_zero: assert property (rd && haddr[7:0] > 8'h0c |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
a_ctrl_reserved: assert property (rd && haddr[7:0] == 8'h00 |=> (hrdata & ~32'h1f3f) == 32'h0)
    else $error("ctrl reserved bits set");
a_status_mirror: assert property (rd && haddr[7:0] == 8'h04 |=>
    hrdata[10:8] == $past({enable_out_n, gated_out, rate_out_n})) else $error("status mismatch");
a_z_sets_y: assert property (!rate_out_n |-> gated_out) else $error("y low on z pulse");

endmodule : brm_checker

`default_nettype wire

//--- test/brm_far_side.sv
`timescale 1ns/1ps
`default_nettype none

module brm_far_side
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       rate_out_n,
    input  wire logic       gated_out,
    input  wire logic       enable_out_n,
    output var  logic [6:0] z_seen,
    output var  logic [6:0] y_seen
);

logic [6:0] z_acc;
logic [6:0] y_acc;

// Counts pulses per window closed by each cycle marker, as a cascaded stage sees them.
always_ff @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        z_acc <= 7'h0;
        y_acc <= 7'h0;
        z_seen <= 7'h0;
        y_seen <= 7'h0;
    end
    else if (!enable_out_n)
    begin
        z_seen <= z_acc + 7'(!rate_out_n);
        y_seen <= y_acc + 7'(gated_out);
        z_acc <= 7'h0;
        y_acc <= 7'h0;
    end
    else
    begin
        z_acc <= z_acc + 7'(!rate_out_n);
        y_acc <= y_acc + 7'(gated_out);
    end
end

endmodule : brm_far_side

`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
import brm_pkg::*;

logic        hclk = 0;
logic        hresetn = 1;
logic        hsel = 0;
logic        hwrite = 0;
logic [31:0] haddr = 0;
logic [31:0] hwdata = 0;
logic [31:0] rd;
logic [1:0]  htrans = 0;
logic [2:0]  hsize = 3'b010;
logic        b;
logic [5:0]  c;
wire logic [31:0] hrdata;
wire logic   hready, hreadyout, hresp, rate_out_n, gated_out, enable_out_n;
wire logic [6:0] z_seen, y_seen;
int          bad_count = 0;
int          check_count = 0;
int          cyc = 0;
int          rates[9] = '{0, 1, 2, 4, 8, 16, 32, 63, 40};
logic [31:0] holds[2] = '{32'h0c3f, 32'h0a3f};

assign hready = hreadyout;
brm_top DUT
(
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hready),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .rate_out_n   (rate_out_n),
    .gated_out    (gated_out),
    .enable_out_n (enable_out_n)
);

brm_far_side FAR
(
    .hclk         (hclk),
    .hresetn      (hresetn),
    .rate_out_n   (rate_out_n),
    .gated_out    (gated_out),
    .enable_out_n (enable_out_n),
    .z_seen       (z_seen),
    .y_seen       (y_seen)
);

initial forever #20 hclk = ~hclk;

task give_verdict;
    if (bad_count == 0 && check_count > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask : give_verdict

always @(posedge hclk)
begin
    cyc++;
    if (cyc > 20000)
    begin
        bad_count++;
        give_verdict();
    end
end

task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
        bad_count++;
        $display("ERROR %s expected %h seen %h", n, e, s);
    end
endtask : chk

task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
endtask : xfer

task automatic run_rate(input int r, input logic u);
    xfer(1'b1, 32'h0, (u ? 32'h800 : 32'h0) | 32'(r[5:0]));
    repeat (140) @(posedge hclk);
    xfer(1'b0, 32'h08, 32'h0);
    chk("z_count", r, rd[6:0]);
    chk("y_count", u ? r : 64, rd[14:8]);
    chk("far_z", r, z_seen);
    chk("far_y", u ? r : 64, y_seen);
endtask : run_rate

initial
begin
    hresetn <= 1'b0;
    void'($urandom(32'h7730d2f4));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, 32'h0, 32'h0);
    chk("ctrl_reset", 32'h0e00, rd);
    xfer(1'b1, 32'h40, 32'hffff);
    xfer(1'b0, 32'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    xfer(1'b0, 32'h0, 32'h0);
    chk("ctrl_kept", 32'h0e00, rd);
    foreach (rates[i]) run_rate(rates[i], 1'b1);
    run_rate(63, 1'b0);
    repeat (3) run_rate($urandom_range(63), 1'($urandom_range(1)));
    foreach (holds[i])
    begin
        xfer(1'b1, 32'h0, holds[i]);
        xfer(1'b0, 32'h04, 32'h0);
        c = rd[5:0];
        repeat (20) @(posedge hclk);
        xfer(1'b0, 32'h04, 32'h0);
        chk("hold_cnt", c, rd[5:0]);
        chk("hold_z", 1, rd[8]);
    end
    xfer(1'b1, 32'h0, 32'h0d00);
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    chk("clr_y", 0, gated_out);
    chk("clr_en", 1, enable_out_n);
    @(posedge hclk);
    xfer(1'b0, 32'h04, 32'h0);
    chk("clr_cnt", 0, rd[5:0]);
    xfer(1'b1, 32'h0, 32'h1c00);
    // The first output after the write still comes from the clear setting.
    repeat (2) @(negedge hclk);
    for (int i = 0; i < 8; i++)
    begin
        b = gated_out;
        @(negedge hclk);
        chk("y_clock", !b, gated_out);
    end
    give_verdict();
end

endmodule : testbench

bind brm_top brm_checker chk_i
(
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hready       (hready),
    .hrdata       (hrdata),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .rate_out_n   (rate_out_n),
    .gated_out    (gated_out),
    .enable_out_n (enable_out_n)
);

`default_nettype wire
